// [fcd_consts.svh]
// Purpose: Constants for the flash command decoder
// Assumes: 40 MHz system clock
// Notes:   Offsets are low address bits A11-A0 only
`ifndef FCD_CONSTS_SVH
`define FCD_CONSTS_SVH
`define FCD_ADDR_555       12'h555
`define FCD_ADDR_AAA       12'hAAA
`define FCD_D_UNLK1        8'hAA
`define FCD_D_UNLK2        8'h55
`define FCD_D_PROT         8'h90
`define FCD_D_PROG         8'hA0
`define FCD_D_ERASE        8'h80
`define FCD_D_SECT         8'h30
`define FCD_D_BULK         8'h10
`define FCD_D_SUSP         8'hB0
`define FCD_D_RESET        8'hF0
`define FCD_D_BYPASS       8'h20
`define FCD_D_BYP_EXIT     8'h00
`define FCD_PROT_A10       2'h2
`define FCD_STAT_UNPROT    8'h00
`define FCD_STAT_PROT      8'h01
`define FCD_CLK_MHZ        40
`define FCD_ADD_WIN_US     80
`define FCD_ADD_WIN_CYC    (`FCD_ADD_WIN_US * `FCD_CLK_MHZ)
`endif

// [fcd_pkg.sv]
// Purpose: Types for the flash command decoder
// Assumes: Nothing
// Notes:   Constants live in fcd_consts.svh
package fcd_pkg;
  typedef enum logic [3:0] {
    FCD_ST_READ, FCD_ST_UNLK1, FCD_ST_UNLK2, FCD_ST_PROG,
    FCD_ST_ERS1, FCD_ST_ERS2, FCD_ST_ERS3, FCD_ST_PROT,
    FCD_ST_BYP, FCD_ST_BYP_PROG, FCD_ST_BYP_EXIT
  } fcd_state_e;
  typedef enum logic [1:0] {
    FCD_ER_IDLE, FCD_ER_WINDOW, FCD_ER_RUN, FCD_ER_SUSP
  } fcd_erase_e;
endpackage

// [fcd_flash_command_decoder.sv]
// Purpose: Decodes processor write sequences into flash array commands
// Assumes: Strobes synchronous to i_sys_clk, held at least one cycle
// Notes:   Embedded algorithms sit outside; they report erase completion
`timescale 1ns/1ps
`include "fcd_consts.svh"
`default_nettype none
module fcd_flash_command_decoder (
  input  wire logic        i_sys_clk,
  input  wire logic        i_srst,
  input  wire logic        i_wr_n,
  input  wire logic        i_rd_n,
  input  wire logic [15:0] i_addr,
  input  wire logic [7:0]  i_data,
  input  wire logic [7:0]  i_primary_sector_selects,
  input  wire logic [3:0]  i_secondary_sector_selects,
  input  wire logic        i_sector_protected,
  input  wire logic        i_erase_done,
  output logic             o_read_mode,
  output logic             o_bypass_mode,
  output logic             o_prot_query,
  output logic             o_id_read_en,
  output logic             o_prog_req,
  output logic             o_bulk_erase_req,
  output logic             o_reset_req,
  output logic             o_target_secondary,
  output logic [15:0]      o_program_address,
  output logic [7:0]       o_program_data,
  output logic [11:0]      o_erase_sectors,
  output logic             o_erase_running,
  output logic             o_erase_suspended,
  output logic [7:0]       o_status_data,
  output logic             o_status_valid
);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Coded cycle match on low twelve address bits
  function automatic logic code_hit(input logic [15:0] a, input logic [7:0] d,
                                    input logic [11:0] ea, input logic [7:0] ed);
    code_hit = (a[11:0] == ea) && (d == ed);
  endfunction

  // Don't care address cycle, must be even
  function automatic logic even_hit(input logic [15:0] a, input logic [7:0] d,
                                    input logic [7:0] ed);
    even_hit = (a[0] == 1'b0) && (d == ed);
  endfunction

  // ---------------------------------------------------------------
  // Strobe edges and capture
  // ---------------------------------------------------------------
  logic                wr_n_reg;
  logic [15:0]         addr_lat_reg;
  logic [11:0]         sel_lat_reg;
  logic                wr_fall;
  logic                wr_rise;
  logic                prim_any;
  logic                sec_any;
  logic                sel_ok;
  logic [11:0]         sel_now;

  assign wr_fall  = wr_n_reg & ~i_wr_n;
  assign wr_rise  = ~wr_n_reg & i_wr_n;
  assign sel_now  = {i_secondary_sector_selects, i_primary_sector_selects};
  assign prim_any = |sel_lat_reg[7:0];
  assign sec_any  = |sel_lat_reg[11:8];
  assign sel_ok   = prim_any | sec_any;

  // Strobe history
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      wr_n_reg <= 1'b1;
    end else begin
      wr_n_reg <= i_wr_n;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      addr_lat_reg <= 16'h0000;
      sel_lat_reg  <= 12'h000;
    end else if (wr_fall) begin
      addr_lat_reg <= i_addr;
      sel_lat_reg  <= sel_now;
    end
  end

  // ---------------------------------------------------------------
  // Command sequencer
  // ---------------------------------------------------------------
  fcd_pkg::fcd_state_e state_reg;
  fcd_pkg::fcd_state_e state_next;
  fcd_pkg::fcd_erase_e erase_reg;
  fcd_pkg::fcd_erase_e erase_next;
  logic [11:0]         win_cnt_reg;
  logic [11:0]         win_cnt_next;
  logic [11:0]         erase_mask_reg;
  logic [11:0]         erase_mask_next;
  logic                prog_next;
  logic                bulk_next;
  logic                reset_next;
  logic                wr_ev;
  logic                blocked;

  // Decoded write: rising edge with a selected array
  assign wr_ev   = wr_rise & sel_ok;
  // no program into sectors under a suspended erase
  assign blocked = (erase_reg == fcd_pkg::FCD_ER_SUSP) && |(sel_lat_reg & erase_mask_reg);

  // Next state of the command sequence
  always_comb begin
    state_next      = state_reg;
    erase_next      = erase_reg;
    win_cnt_next    = win_cnt_reg;
    erase_mask_next = erase_mask_reg;
    prog_next       = 1'b0;
    bulk_next       = 1'b0;
    reset_next      = 1'b0;
    // Erase window countdown and completion
    if (erase_reg == fcd_pkg::FCD_ER_WINDOW) begin
      if (win_cnt_reg == 12'h000) begin
        erase_next = fcd_pkg::FCD_ER_RUN;
      end else begin
        win_cnt_next = win_cnt_reg - 12'h001;
      end
    end
    if (i_erase_done && (erase_reg == fcd_pkg::FCD_ER_RUN)) begin
      erase_next      = fcd_pkg::FCD_ER_IDLE;
      erase_mask_next = 12'h000;
    end
    if (wr_ev) begin
      state_next = fcd_pkg::FCD_ST_READ;
      case (state_reg)
        fcd_pkg::FCD_ST_READ: begin
          if (code_hit(addr_lat_reg, i_data, `FCD_ADDR_555, `FCD_D_UNLK1)) begin
            state_next = fcd_pkg::FCD_ST_UNLK1;
          end else if (even_hit(addr_lat_reg, i_data, `FCD_D_RESET)) begin
            reset_next = 1'b1;
          end else if (even_hit(addr_lat_reg, i_data, `FCD_D_SUSP) &&
                       (erase_reg == fcd_pkg::FCD_ER_RUN) && !i_erase_done) begin
            erase_next = fcd_pkg::FCD_ER_SUSP;
          end else if (even_hit(addr_lat_reg, i_data, `FCD_D_SECT) &&
                       (erase_reg == fcd_pkg::FCD_ER_SUSP)) begin
            erase_next = fcd_pkg::FCD_ER_RUN;
          end else if ((i_data == `FCD_D_SECT) &&
                       (erase_reg == fcd_pkg::FCD_ER_WINDOW)) begin
            erase_mask_next = erase_mask_reg | sel_lat_reg;
            win_cnt_next    = 12'(`FCD_ADD_WIN_CYC - 1);
            erase_next      = fcd_pkg::FCD_ER_WINDOW;
          end
        end
        fcd_pkg::FCD_ST_UNLK1: begin
          if (code_hit(addr_lat_reg, i_data, `FCD_ADDR_AAA, `FCD_D_UNLK2)) begin
            state_next = fcd_pkg::FCD_ST_UNLK2;
          end
        end
        fcd_pkg::FCD_ST_UNLK2: begin
          if (code_hit(addr_lat_reg, i_data, `FCD_ADDR_555, `FCD_D_PROT)) begin
            state_next = fcd_pkg::FCD_ST_PROT;
          end else if (code_hit(addr_lat_reg, i_data, `FCD_ADDR_555, `FCD_D_PROG)) begin
            state_next = fcd_pkg::FCD_ST_PROG;
          end else if (code_hit(addr_lat_reg, i_data, `FCD_ADDR_555, `FCD_D_ERASE) &&
                       (erase_reg == fcd_pkg::FCD_ER_IDLE)) begin
            state_next = fcd_pkg::FCD_ST_ERS1;
          end else if (code_hit(addr_lat_reg, i_data, `FCD_ADDR_555, `FCD_D_BYPASS)) begin
            state_next = fcd_pkg::FCD_ST_BYP;
          end
        end
        fcd_pkg::FCD_ST_PROG: begin
          prog_next = ~blocked;
        end
        fcd_pkg::FCD_ST_ERS1: begin
          if (code_hit(addr_lat_reg, i_data, `FCD_ADDR_555, `FCD_D_UNLK1)) begin
            state_next = fcd_pkg::FCD_ST_ERS2;
          end
        end
        fcd_pkg::FCD_ST_ERS2: begin
          if (code_hit(addr_lat_reg, i_data, `FCD_ADDR_AAA, `FCD_D_UNLK2)) begin
            state_next = fcd_pkg::FCD_ST_ERS3;
          end
        end
        fcd_pkg::FCD_ST_ERS3: begin
          if (i_data == `FCD_D_SECT) begin
            erase_mask_next = sel_lat_reg;
            win_cnt_next    = 12'(`FCD_ADD_WIN_CYC - 1);
            erase_next      = fcd_pkg::FCD_ER_WINDOW;
          end else if (code_hit(addr_lat_reg, i_data, `FCD_ADDR_555, `FCD_D_BULK)) begin
            bulk_next = 1'b1;
          end
        end
        fcd_pkg::FCD_ST_PROT: begin
          reset_next = even_hit(addr_lat_reg, i_data, `FCD_D_RESET);
        end
        fcd_pkg::FCD_ST_BYP: begin
          state_next = fcd_pkg::FCD_ST_BYP;
          if (even_hit(addr_lat_reg, i_data, `FCD_D_PROG)) begin
            state_next = fcd_pkg::FCD_ST_BYP_PROG;
          end else if (even_hit(addr_lat_reg, i_data, `FCD_D_PROT)) begin
            state_next = fcd_pkg::FCD_ST_BYP_EXIT;
          end
        end
        fcd_pkg::FCD_ST_BYP_PROG: begin
          prog_next  = ~blocked;
          state_next = fcd_pkg::FCD_ST_BYP;
        end
        fcd_pkg::FCD_ST_BYP_EXIT: begin
          if (!even_hit(addr_lat_reg, i_data, `FCD_D_BYP_EXIT)) begin
            state_next = fcd_pkg::FCD_ST_BYP;
          end
        end
        default: begin
          state_next = fcd_pkg::FCD_ST_READ;
        end
      endcase
    end
  end

  // Sequence and erase state
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      state_reg      <= fcd_pkg::FCD_ST_READ;
      erase_reg      <= fcd_pkg::FCD_ER_IDLE;
      win_cnt_reg    <= 12'h000;
      erase_mask_reg <= 12'h000;
    end else begin
      state_reg      <= state_next;
      erase_reg      <= erase_next;
      win_cnt_reg    <= win_cnt_next;
      erase_mask_reg <= erase_mask_next;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // Command pulses, mode levels, program capture
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      o_prog_req         <= 1'b0;
      o_bulk_erase_req   <= 1'b0;
      o_reset_req        <= 1'b0;
      o_read_mode        <= 1'b1;
      o_bypass_mode      <= 1'b0;
      o_prot_query       <= 1'b0;
      o_id_read_en       <= 1'b0;
      o_target_secondary <= 1'b0;
      o_program_address  <= 16'h0000;
      o_program_data     <= 8'h00;
      o_erase_sectors    <= 12'h000;
      o_erase_running    <= 1'b0;
      o_erase_suspended  <= 1'b0;
    end else begin
      o_prog_req         <= prog_next;
      o_bulk_erase_req   <= bulk_next;
      o_reset_req        <= reset_next;
      // plain reads served in read mode
      o_read_mode        <= (state_next == fcd_pkg::FCD_ST_READ);
      o_bypass_mode      <= (state_next == fcd_pkg::FCD_ST_BYP) ||
                            (state_next == fcd_pkg::FCD_ST_BYP_PROG) ||
                            (state_next == fcd_pkg::FCD_ST_BYP_EXIT);
      o_prot_query       <= (state_next == fcd_pkg::FCD_ST_PROT);
      o_id_read_en       <= (state_next == fcd_pkg::FCD_ST_PROT) && prim_any;
      o_erase_sectors    <= erase_mask_next;
      o_erase_running    <= (erase_next == fcd_pkg::FCD_ER_WINDOW) ||
                            (erase_next == fcd_pkg::FCD_ER_RUN);
      o_erase_suspended  <= (erase_next == fcd_pkg::FCD_ER_SUSP);
      if (wr_ev) begin
        o_target_secondary <= ~prim_any & sec_any;
      end
      // address latched at strobe fall, data taken at rising edge
      if (prog_next) begin
        o_program_address <= addr_lat_reg;
        o_program_data    <= i_data;
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      o_status_data  <= 8'h00;
      o_status_valid <= 1'b0;
    end else begin
      o_status_valid <= (state_reg == fcd_pkg::FCD_ST_PROT) && !i_rd_n &&
                        (|sel_now) && (i_addr[1:0] == `FCD_PROT_A10);
      o_status_data  <= i_sector_protected ? `FCD_STAT_PROT : `FCD_STAT_UNPROT;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  a_prog_pulse_one: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    o_prog_req |=> !o_prog_req) else $error("program pulse longer than one cycle");
  a_prog_data_cap: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    prog_next |=> (o_program_data == $past(i_data))) else $error("program data not captured");
  a_prog_addr_cap: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    prog_next |=> (o_program_address == $past(addr_lat_reg))) else $error("bad program address");
  a_unlock_two: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    (state_reg == fcd_pkg::FCD_ST_UNLK1) && wr_ev &&
    ((addr_lat_reg[11:0] != `FCD_ADDR_AAA) || (i_data != `FCD_D_UNLK2)) |=> o_read_mode)
    else $error("bad unlock kept");
  a_no_sel_hold: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    wr_rise && !sel_ok |=> $stable(state_reg)) else $error("write without select decoded");
  a_suspend_gate: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    $rose(o_erase_suspended) |-> $past(erase_reg == fcd_pkg::FCD_ER_RUN))
    else $error("suspend outside erase");
  a_bypass_hold: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    (state_reg == fcd_pkg::FCD_ST_BYP) && wr_ev |=> o_bypass_mode) else $error("bypass lost");
  a_prot_status: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    o_status_valid |-> (o_status_data[7:1] == 7'h00)) else $error("bad protection data");
  a_win_bound: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    win_cnt_reg <= 12'(`FCD_ADD_WIN_CYC - 1)) else $error("erase window overrun");
  a_prot_exit: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    (state_reg == fcd_pkg::FCD_ST_PROT) && wr_ev |=> !o_prot_query) else $error("query stuck");

endmodule
`default_nettype wire

// [fcd_proc_model.sv]
// Purpose: Processor model issuing bus writes and reads to the decoder
// Assumes: Requests change just after a rising clock edge
// Notes:   Released data shows inverted values; wr puts the address back to its last value
`timescale 1ns/1ps
`default_nettype none
module fcd_proc_model (
  input  wire logic        i_sys_clk,
  output logic             o_wr_n,
  output logic             o_rd_n,
  output logic [15:0]      o_addr,
  output logic [7:0]       o_data,
  output logic [7:0]       o_psel,
  output logic [3:0]       o_ssel
);
  // --------------------------------------------------------------
  // Idle bus
  // --------------------------------------------------------------
  initial begin
    o_wr_n = 1'b1;
    o_rd_n = 1'b1;
    {o_ssel, o_psel, o_addr, o_data} = 36'h0;
  end

  // Address valid at strobe fall, data at rise
  // Caller gives even don't-care addresses, except odd 16'h8001 for an added erase sector, runs elsewhere
  task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic [11:0] sel);
    @(posedge i_sys_clk);
    o_wr_n <= 1'b0;
    {o_ssel, o_psel, o_addr, o_data} <= {sel, a, ~d};
    @(posedge i_sys_clk);
    {o_addr, o_data} <= {~a, d};   // Address no longer valid
    @(posedge i_sys_clk);
    o_wr_n <= 1'b1;
    @(posedge i_sys_clk);
    {o_ssel, o_psel, o_addr, o_data} <= {12'h000, a, ~d};
  endtask

  task automatic rd(input logic [15:0] a, input logic [11:0] sel);
    @(posedge i_sys_clk);
    o_rd_n <= 1'b0;
    {o_ssel, o_psel, o_addr} <= {sel, a};
    @(posedge i_sys_clk);
    o_rd_n <= 1'b1;
    {o_ssel, o_psel, o_addr} <= {12'h000, ~a};
  endtask
endmodule
`default_nettype wire

// [tb_flash_command_decoder.sv]
// Purpose: Self-checking bench for the flash command decoder
// Assumes: 40 MHz clock, pulses one clock after the strobe rise
// Notes:   Pulses are counted by a monitor; scenarios compare deltas
`timescale 1ns/1ps
`include "fcd_consts.svh"
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin err_total++; \
  $display("[ERR] %s expected %0h seen %0h", nm, e, g); end end
module tb_flash_command_decoder;
  logic i_sys_clk, i_srst, i_wr_n, i_rd_n, i_sector_protected, i_erase_done;
  logic [15:0] i_addr;
  logic [7:0]  i_data, i_psel, o_program_data, o_status_data;
  logic [3:0]  i_ssel;
  logic o_read_mode, o_bypass_mode, o_prot_query, o_id_read_en, o_prog_req;
  logic o_bulk_erase_req, o_reset_req, o_target_secondary, o_erase_running;
  logic o_erase_suspended, o_status_valid;
  logic [15:0] o_program_address, pa_seen;
  logic [11:0] o_erase_sectors;
  logic [7:0]  pd_seen, st_seen;
  int err_total, checks, n_prog, n_bulk, n_rst, n_stat, k;

  // --------------------------------------------------------------
  // Clock, parts
  // --------------------------------------------------------------
  initial begin
    i_sys_clk = 1'b0;
    forever #12.5 i_sys_clk = ~i_sys_clk;
  end
  fcd_proc_model proc (.i_sys_clk(i_sys_clk), .o_wr_n(i_wr_n), .o_rd_n(i_rd_n),
    .o_addr(i_addr), .o_data(i_data), .o_psel(i_psel), .o_ssel(i_ssel));
  fcd_flash_command_decoder uut (.i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_wr_n(i_wr_n),
    .i_rd_n(i_rd_n), .i_addr(i_addr), .i_data(i_data), .i_primary_sector_selects(i_psel),
    .i_secondary_sector_selects(i_ssel), .i_sector_protected(i_sector_protected),
    .i_erase_done(i_erase_done), .o_read_mode(o_read_mode), .o_bypass_mode(o_bypass_mode),
    .o_prot_query(o_prot_query), .o_id_read_en(o_id_read_en), .o_prog_req(o_prog_req),
    .o_bulk_erase_req(o_bulk_erase_req), .o_reset_req(o_reset_req),
    .o_target_secondary(o_target_secondary), .o_program_address(o_program_address),
    .o_program_data(o_program_data), .o_erase_sectors(o_erase_sectors),
    .o_erase_running(o_erase_running), .o_erase_suspended(o_erase_suspended),
    .o_status_data(o_status_data), .o_status_valid(o_status_valid));

  // Pulse and status monitor
  always @(posedge i_sys_clk) begin
    if (o_prog_req === 1'b1) begin
      n_prog++;
      pa_seen = o_program_address;
      pd_seen = o_program_data;
    end
    if (o_bulk_erase_req === 1'b1) n_bulk++;
    if (o_reset_req === 1'b1) n_rst++;
    if (o_status_valid === 1'b1) begin
      n_stat++;
      st_seen = o_status_data;
    end
  end

  // --------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------
  task automatic settle();
    repeat (2) @(posedge i_sys_clk);
  endtask
  task automatic unl(input logic [11:0] sel);
    proc.wr(16'hF555, 8'hAA, sel);
    proc.wr(16'h3AAA, 8'h55, sel);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  task automatic t_program(input logic [11:0] sel, input logic [15:0] a, input logic [7:0] d);
    k = n_prog;
    unl(sel);
    proc.wr(16'h9555, 8'hA0, sel);
    proc.wr(a, d, sel);
    settle();
    `CHK("prog pulses", k + 1, n_prog)
    `CHK("prog addr", a, pa_seen)
    `CHK("prog data", d, pd_seen)
    `CHK("target sec", |sel[11:8], o_target_secondary)
  endtask
  task automatic t_query();
    k = n_stat;
    unl(12'h010);
    proc.wr(16'h2555, 8'h90, 12'h010);
    settle();
    `CHK("query", 1'b1, o_prot_query)
    `CHK("id read", 1'b1, o_id_read_en)
    i_sector_protected <= 1'b1;
    proc.rd(16'h5002, 12'h010);
    settle();
    `CHK("stat prot", 8'h01, st_seen)
    i_sector_protected <= 1'b0;
    proc.rd(16'h5002, 12'h010);
    settle();
    `CHK("stat unprot", 8'h00, st_seen)
    `CHK("stat reads", k + 2, n_stat)
    k = n_rst;
    proc.wr(16'h0000, 8'hF0, 12'h010);
    settle();
    `CHK("reset pulse", k + 1, n_rst)
    `CHK("read mode", 1'b1, o_read_mode)
    unl(12'h400);
    proc.wr(16'h0555, 8'h90, 12'h400);
    settle();
    `CHK("sec id read", 1'b0, o_id_read_en)
    proc.wr(16'h0000, 8'hF0, 12'h400);
  endtask
  task automatic t_mismatch();
    k = n_prog;
    proc.wr(16'h0555, 8'hAA, 12'h001);
    proc.wr(16'h0AAA, 8'h56, 12'h001);
    proc.wr(16'h0555, 8'hA0, 12'h001);
    proc.wr(16'h1234, 8'h5A, 12'h001);
    unl(12'h000);
    proc.wr(16'h0555, 8'hA0, 12'h000);
    proc.wr(16'h1234, 8'h5A, 12'h000);
    settle();
    `CHK("no prog", k, n_prog)
    `CHK("read mode", 1'b1, o_read_mode)
  endtask
  task automatic t_erase();
    unl(12'h004);
    proc.wr(16'h0555, 8'h80, 12'h004);
    unl(12'h004);
    proc.wr(16'h4000, 8'h30, 12'h004);
    settle();
    `CHK("running", 1'b1, o_erase_running)
    `CHK("sectors", 12'h004, o_erase_sectors)
    repeat (100) @(posedge i_sys_clk);
    proc.wr(16'h8001, 8'h30, 12'h200);
    settle();
    `CHK("more sectors", 12'h204, o_erase_sectors)
    repeat (`FCD_ADD_WIN_CYC + 10) @(posedge i_sys_clk);
    proc.wr(16'h0000, 8'hB0, 12'h001);
    settle();
    `CHK("suspended", 1'b1, o_erase_suspended)
    t_program(12'h020, 16'h6000, 8'h3C);
    k = n_prog;
    unl(12'h004);
    proc.wr(16'h0555, 8'hA0, 12'h004);
    proc.wr(16'h4010, 8'h11, 12'h004);
    settle();
    `CHK("blocked prog", k, n_prog)
    proc.wr(16'h0000, 8'h30, 12'h001);
    settle();
    `CHK("resumed", 1'b0, o_erase_suspended)
    `CHK("run again", 1'b1, o_erase_running)
    i_erase_done <= 1'b1;
    @(posedge i_sys_clk);
    i_erase_done <= 1'b0;
    settle();
    `CHK("erase over", 1'b0, o_erase_running)
    proc.wr(16'h0000, 8'hB0, 12'h001);
    settle();
    `CHK("no suspend", 1'b0, o_erase_suspended)
  endtask
  task automatic t_bulk(input logic [7:0] fifth, input int exp);
    k = n_bulk;
    unl(12'h002);
    proc.wr(16'h0555, 8'h80, 12'h002);
    proc.wr(16'h0555, 8'hAA, 12'h002);
    proc.wr(16'h0AAA, fifth, 12'h002);
    proc.wr(16'h0555, 8'h10, 12'h002);
    settle();
    `CHK("bulk pulses", k + exp, n_bulk)
    `CHK("read mode", 1'b1, o_read_mode)
  endtask
  task automatic t_bypass();
    unl(12'h100);
    proc.wr(16'h0555, 8'h20, 12'h100);
    settle();
    `CHK("bypass", 1'b1, o_bypass_mode)
    k = n_prog;
    proc.wr(16'h1002, 8'hA0, 12'h100);
    proc.wr(16'h2345, 8'h77, 12'h100);
    settle();
    `CHK("byp prog", k + 1, n_prog)
    `CHK("byp addr", 16'h2345, pa_seen)
    k = n_rst;
    proc.wr(16'h0000, 8'hF0, 12'h100);
    settle();
    `CHK("no reset", k, n_rst)
    `CHK("still bypass", 1'b1, o_bypass_mode)
    proc.wr(16'h0004, 8'h90, 12'h100);
    proc.wr(16'h0006, 8'h00, 12'h100);
    settle();
    `CHK("bypass left", 1'b0, o_bypass_mode)
    `CHK("read mode", 1'b1, o_read_mode)
  endtask

  // --------------------------------------------------------------
  // Main sequence and watchdog
  // --------------------------------------------------------------
  initial begin
    {err_total, checks, n_prog, n_bulk, n_rst, n_stat} = '0;
    i_srst = 1'b1;
    i_sector_protected = 1'b0;
    i_erase_done = 1'b0;
    repeat (4) @(posedge i_sys_clk);
    i_srst <= 1'b0;
    settle();
    `CHK("reset read", 1'b1, o_read_mode)
    `CHK("reset run", 1'b0, o_erase_running)
    t_program(12'h001, 16'hC123, 8'h5A);
    t_program(12'h800, 16'h0FFE, 8'hA5);
    t_query();
    t_mismatch();
    t_erase();
    t_bulk(8'h55, 1);
    t_bulk(8'h54, 0);
    t_bypass();
    tally_and_finish();
  end
  initial begin
    repeat (20000) @(posedge i_sys_clk);
    err_total++;
    $display("[ERR] watchdog expected done seen hang");
    tally_and_finish();
  end
endmodule
`default_nettype wire
